// file: kpe_pkg.sv
// Package with constants and types shared by the keypad event handler.
package kpe_pkg;

  // ==========================================================================
  // Sizes
  localparam int KEYS = 25;
  localparam int KEY_W = 5;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 10;
  localparam int BUF_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int LOAD_W = 6;
  localparam logic [LOAD_W-1:0] LOAD_LAST = 6'h31;
  localparam logic [LOAD_W-1:0] LOAD_UP_FIRST = 6'h19;
  localparam logic [BUF_W-1:0] BUF_LAST = 4'h9;
  localparam logic [BUF_W-1:0] BUF_FULL = 4'ha;
  localparam logic [BUF_W-1:0] BUF_ONE = 4'h1;
  localparam int MORE_BIT = 7;

  // ==========================================================================
  // Command bytes
  localparam logic [7:0] PREFIX = 8'hfe;
  localparam logic [7:0] CMD_AUTO_OFF = 8'h4f;
  localparam logic [7:0] CMD_CLEAR = 8'h45;
  localparam logic [7:0] CMD_DEBOUNCE = 8'h55;
  localparam logic [7:0] CMD_REP_MODE = 8'h7e;
  localparam logic [7:0] CMD_ASSIGN = 8'hd5;
  // Defaults for the three codes that the host side must agree on.
  localparam logic [7:0] DEF_AUTO_EN = 8'h41;
  localparam logic [7:0] DEF_POLL = 8'h26;
  localparam logic [7:0] DEF_REP_OFF = 8'h60;
  localparam logic [7:0] KEEP_CODE = 8'hff;
  localparam logic [7:0] MODE_HOLD = 8'h01;
  localparam logic [7:0] POLL_EMPTY = 8'h00;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DEB_DEFAULT = 8'h08;
  localparam logic [7:0] DOWN_BASE = 8'h41;
  localparam logic [7:0] UP_BASE = 8'h61;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEB_TICK_NS = 6554000;
  localparam int REP_DELAY_NS = 1000000000;
  localparam int REP_RATE_HZ = 5;
  localparam int REP_PERIOD_NS = REP_DELAY_NS / REP_RATE_HZ;
  localparam int DEB_TICK_CYC = DEB_TICK_NS / CLK_PERIOD_NS;
  localparam int REP_DELAY_CYC = REP_DELAY_NS / CLK_PERIOD_NS;
  localparam int REP_PERIOD_CYC = REP_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } kpe_byte_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD = 5'b00010,
    ST_DEB = 5'b00100,
    ST_MODE = 5'b01000,
    ST_LOAD = 5'b10000
  } kpe_state_t;

endpackage

// file: keypad_event_handler.sv
// Keypad event handler: debounce, repeat, key buffer, command parser, FIFO.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Output FIFO
module kpe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid_ff,
  output logic [WIDTH-1:0] outData_ff,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  // Full is honest: the output stage is extra room, not counted here.
  assign inReady = (count_ff != CNT_FULL);
  assign push = inValid && inReady;
  assign pop = (count_ff != '0) && (!outValid_ff || outReady);

  // Storage is written without reset; only pointers need a defined value.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == PTR_LAST) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == PTR_LAST) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  // Registered output stage so the port comes straight from a flip-flop.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid_ff <= 1'b0;
      outData_ff <= '0;
    end else if (pop) begin
      outValid_ff <= 1'b1;
      outData_ff <= mem[rdPtr_ff];
    end else if (outReady) begin
      outValid_ff <= 1'b0;
    end
  end
endmodule // kpe_fifo

// ============================================================================
// Top level
module keypad_event_handler
  import kpe_pkg::*;
#(
  parameter logic [7:0] CMD_AUTO_EN = DEF_AUTO_EN,
  parameter logic [7:0] CMD_POLL = DEF_POLL,
  parameter logic [7:0] CMD_REP_OFF = DEF_REP_OFF,
  parameter int TICK_CYC = DEB_TICK_CYC,
  parameter int DELAY_CYC = REP_DELAY_CYC,
  parameter int PERIOD_CYC = REP_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [KEYS-1:0] keyRaw,
  input wire kpe_byte_t rxIn,
  output kpe_byte_t txOut,
  input wire logic txReady,
  output logic autoTx_ff,
  output logic [BUF_W-1:0] bufCount_ff
);
  kpe_state_t state_ff;
  logic [7:0] debArg_ff;
  logic holdMode_ff;
  logic repOff_ff;
  logic [LOAD_W-1:0] loadIdx_ff;
  logic [7:0] downCode_ff [KEYS];
  logic [7:0] upCode_ff [KEYS];
  logic [31:0] tickCnt_ff;
  logic tick;
  logic [KEYS-1:0] stable_ff;
  logic [KEYS-1:0] pendDown_ff;
  logic [KEYS-1:0] pendUp_ff;
  logic [KEYS-1:0] pressAcc;
  logic [KEYS-1:0] relAcc;
  logic [KEYS-1:0] serveSel;
  logic repActive_ff;
  logic repPend_ff;
  logic [KEY_W-1:0] repKey_ff;
  logic [31:0] repCnt_ff;
  logic [7:0] keyBuf_ff [BUF_DEPTH];
  logic [BUF_W-1:0] bufRd_ff;
  logic [BUF_W-1:0] bufWr_ff;
  logic pollPend_ff;
  logic evtValid;
  logic evtIsRep;
  logic [KEY_W-1:0] evtKey;
  logic [7:0] evtCode;
  logic evtServe;
  logic bufStore;
  logic pollPush;
  logic fifoValid;
  logic [7:0] fifoData;
  logic fifoReady;
  logic cmdPoll;
  logic cmdClear;
  logic pressSeen;
  logic [KEY_W-1:0] pressKey;

  // ==========================================================================
  // Command parser
  // Command byte decode while the parser waits for it.
  assign cmdPoll = rxIn.valid && (state_ff == ST_CMD) && (rxIn.data == CMD_POLL);
  assign cmdClear = rxIn.valid && (state_ff == ST_CMD) && (rxIn.data == CMD_CLEAR);

  // Unknown command bytes fall back to idle so the parser resynchronises.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      loadIdx_ff <= '0;
    end else if (rxIn.valid) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (rxIn.data == PREFIX) begin
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          loadIdx_ff <= '0;
          if (rxIn.data == CMD_DEBOUNCE) begin
            state_ff <= ST_DEB;
          end else if (rxIn.data == CMD_REP_MODE) begin
            state_ff <= ST_MODE;
          end else if (rxIn.data == CMD_ASSIGN) begin
            state_ff <= ST_LOAD;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        ST_DEB, ST_MODE: begin
          state_ff <= ST_IDLE;
        end
        ST_LOAD: begin
          loadIdx_ff <= loadIdx_ff + 1'b1;
          if (loadIdx_ff == LOAD_LAST) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Mode bits set by commands.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      autoTx_ff <= 1'b1;
      debArg_ff <= DEB_DEFAULT;
      holdMode_ff <= 1'b0;
      repOff_ff <= 1'b0;
    end else if (rxIn.valid) begin
      if (state_ff == ST_CMD && rxIn.data == CMD_AUTO_OFF) begin
        autoTx_ff <= 1'b0;
      end
      if (state_ff == ST_CMD && rxIn.data == CMD_AUTO_EN) begin
        autoTx_ff <= 1'b1;
      end
      if (state_ff == ST_CMD && rxIn.data == CMD_REP_OFF) begin
        repOff_ff <= 1'b1;
      end
      if (state_ff == ST_DEB) begin
        debArg_ff <= rxIn.data;
      end
      if (state_ff == ST_MODE) begin
        holdMode_ff <= (rxIn.data == MODE_HOLD);
        repOff_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Key code tables, debounce and per-key event flags
  // One debounce tick of 6.554 ms shared by all keys.
  assign tick = (tickCnt_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_ff <= '0;
    end else begin
      tickCnt_ff <= tick ? '0 : tickCnt_ff + 1'b1;
    end
  end

  for (genvar k = 0; k < KEYS; k++) begin : gKey
    logic [7:0] debCnt_ff;

    // Codes load in row-major order; 255 leaves a slot alone.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        downCode_ff[k] <= DOWN_BASE + 8'(k);
        upCode_ff[k] <= UP_BASE + 8'(k);
      end else if (rxIn.valid && state_ff == ST_LOAD && rxIn.data != KEEP_CODE) begin
        if (loadIdx_ff == LOAD_W'(k)) begin
          downCode_ff[k] <= rxIn.data;
        end
        if (loadIdx_ff == LOAD_UP_FIRST + LOAD_W'(k)) begin
          upCode_ff[k] <= rxIn.data;
        end
      end
    end

    // A change is taken once it has held for the programmed tick count.
    assign pressAcc[k] = (keyRaw[k] != stable_ff[k]) && (debCnt_ff >= debArg_ff)
                         && keyRaw[k];
    assign relAcc[k] = (keyRaw[k] != stable_ff[k]) && (debCnt_ff >= debArg_ff)
                       && !keyRaw[k];

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        debCnt_ff <= '0;
        stable_ff[k] <= 1'b0;
      end else if (keyRaw[k] == stable_ff[k]) begin
        debCnt_ff <= '0;
      end else if (debCnt_ff >= debArg_ff) begin
        stable_ff[k] <= keyRaw[k];
        debCnt_ff <= '0;
      end else if (tick) begin
        debCnt_ff <= debCnt_ff + 1'b1;
      end
    end

    // Up codes exist only in hold mode; set wins over a same-cycle serve.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pendDown_ff[k] <= 1'b0;
        pendUp_ff[k] <= 1'b0;
      end else begin
        if (pressAcc[k]) begin
          pendDown_ff[k] <= 1'b1;
        end else if (serveSel[k] && pendDown_ff[k]) begin
          pendDown_ff[k] <= 1'b0;
        end
        if (relAcc[k] && holdMode_ff && !repOff_ff) begin
          pendUp_ff[k] <= 1'b1;
        end else if (serveSel[k] && !pendDown_ff[k]) begin
          pendUp_ff[k] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Typematic repeat
  // Only the lowest-numbered key pressed in a cycle drives the repeat timer.
  always_comb begin
    pressSeen = 1'b0;
    pressKey = '0;
    for (int i = KEYS - 1; i >= 0; i--) begin
      if (pressAcc[i]) begin
        pressSeen = 1'b1;
        pressKey = KEY_W'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      repActive_ff <= 1'b0;
      repKey_ff <= '0;
      repCnt_ff <= '0;
    end else if (pressSeen && !holdMode_ff && !repOff_ff) begin
      repActive_ff <= 1'b1;
      repKey_ff <= pressKey;
      repCnt_ff <= 32'(DELAY_CYC - 1);
    end else if (!stable_ff[repKey_ff] || holdMode_ff || repOff_ff) begin
      repActive_ff <= 1'b0;
    end else if (repActive_ff) begin
      repCnt_ff <= (repCnt_ff == '0) ? 32'(PERIOD_CYC - 1) : repCnt_ff - 1'b1;
    end
  end

  // A repeat stays due until served; the next one is a full period away.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      repPend_ff <= 1'b0;
    end else if (repActive_ff && repCnt_ff == '0 && stable_ff[repKey_ff]) begin
      repPend_ff <= 1'b1;
    end else if (evtServe && evtIsRep) begin
      repPend_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Event selection and routing
  // Fixed priority: lowest key first, down before up, repeat last.
  always_comb begin
    evtValid = 1'b0;
    evtIsRep = 1'b0;
    evtKey = '0;
    for (int i = KEYS - 1; i >= 0; i--) begin
      if (pendDown_ff[i] || pendUp_ff[i]) begin
        evtValid = 1'b1;
        evtKey = KEY_W'(i);
      end
    end
    if (!evtValid && repPend_ff) begin
      evtValid = 1'b1;
      evtIsRep = 1'b1;
      evtKey = repKey_ff;
    end
  end

  assign evtCode = (evtIsRep || pendDown_ff[evtKey]) ? downCode_ff[evtKey]
                                                     : upCode_ff[evtKey];

  // Auto transmit waits for FIFO room; a buffered event never stalls.
  assign pollPush = pollPend_ff && fifoReady;
  assign evtServe = evtValid && (autoTx_ff ? (fifoReady && !pollPush) : 1'b1);
  assign bufStore = evtServe && !autoTx_ff && (bufCount_ff != BUF_FULL);
  assign serveSel = (evtServe && !evtIsRep) ? (KEYS'(1) << evtKey) : '0;
  assign fifoValid = pollPush || (evtServe && autoTx_ff);

  // The poll reply carries the more-keys flag in its top bit.
  always_comb begin
    fifoData = evtCode;
    if (pollPush) begin
      if (bufCount_ff == '0) begin
        fifoData = POLL_EMPTY;
      end else begin
        fifoData = keyBuf_ff[bufRd_ff];
        fifoData[MORE_BIT] = (bufCount_ff != BUF_ONE);
      end
    end
  end

  // A poll in auto transmit mode is ignored rather than answered.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pollPend_ff <= 1'b0;
    end else if (cmdPoll && !autoTx_ff) begin
      pollPend_ff <= 1'b1;
    end else if (pollPush) begin
      pollPend_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Ten-entry key buffer
  always_ff @(posedge ref_clk) begin
    if (bufStore) begin
      keyBuf_ff[bufWr_ff] <= evtCode;
    end
  end

  // Clear beats both a store and a pop issued in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufRd_ff <= '0;
      bufWr_ff <= '0;
      bufCount_ff <= '0;
    end else if (cmdClear) begin
      bufRd_ff <= '0;
      bufWr_ff <= '0;
      bufCount_ff <= '0;
    end else begin
      if (bufStore) begin
        bufWr_ff <= (bufWr_ff == BUF_LAST) ? '0 : bufWr_ff + 1'b1;
      end
      if (pollPush && bufCount_ff != '0) begin
        bufRd_ff <= (bufRd_ff == BUF_LAST) ? '0 : bufRd_ff + 1'b1;
      end
      bufCount_ff <= bufCount_ff + (bufStore ? 1'b1 : 1'b0)
                     - ((pollPush && bufCount_ff != '0) ? 1'b1 : 1'b0);
    end
  end

  // ==========================================================================
  // Transmit FIFO
  kpe_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) uTxFifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(fifoValid),
    .inData(fifoData),
    .inReady(fifoReady),
    .outValid_ff(txOut.valid),
    .outData_ff(txOut.data),
    .outReady(txReady)
  );
endmodule // keypad_event_handler

`default_nettype wire

// file: kpe_checker_sva.sv
// Port assertions of the keypad event handler.
`timescale 1ns/1ps
`default_nettype none
module kpe_checker
  import kpe_pkg::*;
#(
  parameter logic [7:0] CMD_AUTO_EN = DEF_AUTO_EN,
  parameter logic [7:0] CMD_POLL = DEF_POLL
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [KEYS-1:0] keyRaw,
  input wire kpe_byte_t rxIn,
  input wire kpe_byte_t txOut,
  input wire logic txReady,
  input wire logic autoTx_ff,
  input wire logic [BUF_W-1:0] bufCount_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Command framing
  // A command is the prefix byte followed at once by its command byte.
  sequence s_cmd(logic [7:0] c);
    rxIn.valid && rxIn.data == PREFIX ##1 rxIn.valid && rxIn.data == c;
  endsequence
  sequence s_poll;
    s_cmd(CMD_POLL) ##0 !autoTx_ff && !txOut.valid;
  endsequence
  // ==========================================================================
  // Properties
  property p_reset;
    $rose(rst_n) |-> autoTx_ff && bufCount_ff == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_hold;
    txOut.valid && !txReady |=> txOut.valid && $stable(txOut.data);
  endproperty
  a_hold: assert property (p_hold) else $error("reply dropped");
  property p_off;
    s_cmd(CMD_AUTO_OFF) |-> ##[1:3] !autoTx_ff;
  endproperty
  a_off: assert property (p_off) else $error("auto stays on");
  property p_on;
    s_cmd(CMD_AUTO_EN) |-> ##[1:3] autoTx_ff;
  endproperty
  a_on: assert property (p_on) else $error("auto stays off");
  property p_clear;
    s_cmd(CMD_CLEAR) |-> ##[1:3] bufCount_ff == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer not cleared");
  property p_max;
    bufCount_ff <= BUF_FULL;
  endproperty
  a_max: assert property (p_max) else $error("buffer overfilled");
  property p_empty;
    s_poll ##0 bufCount_ff == '0 |-> ##[2:6] txOut.valid && txOut.data == POLL_EMPTY;
  endproperty
  a_empty: assert property (p_empty) else $error("empty poll wrong");
  property p_more;
    s_poll ##0 bufCount_ff > BUF_ONE |-> ##[2:6] txOut.valid && txOut.data[MORE_BIT];
  endproperty
  a_more: assert property (p_more) else $error("more flag low");
  property p_last;
    s_poll ##0 bufCount_ff == BUF_ONE |-> ##[2:6] txOut.valid && !txOut.data[MORE_BIT];
  endproperty
  a_last: assert property (p_last) else $error("last flag high");
  property p_refuse;
    s_cmd(CMD_POLL) ##0 autoTx_ff && !txOut.valid |=> !txOut.valid [*6];
  endproperty
  a_refuse: assert property (p_refuse) else $error("poll answered");
  // Main scenarios reached.
  c_full: cover property (bufCount_ff == BUF_FULL);
  c_stall: cover property (txOut.valid && !txReady);
  c_poll: cover property (s_poll);
endmodule // kpe_checker
bind keypad_event_handler kpe_checker #(.CMD_AUTO_EN(CMD_AUTO_EN), .CMD_POLL(CMD_POLL)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .keyRaw(keyRaw), .rxIn(rxIn), .txOut(txOut),
  .txReady(txReady), .autoTx_ff(autoTx_ff), .bufCount_ff(bufCount_ff));
`default_nettype wire

// file: kpe_host_model.sv
// Host controller model: sends commands and collects reply bytes.
`timescale 1ns/1ps
`default_nettype none
module kpe_host_model
  import kpe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic stallReq,
  output kpe_byte_t rxIn,
  input wire kpe_byte_t txOut,
  output logic txReady
);
  logic [7:0] got[$];
  // ==========================================================================
  // Link driving
  // Idle link at time zero; ready has its own single driver below.
  initial begin
    rxIn = '0;
  end
  // Prefix, command and arguments go back to back; idle data is inverted so
  // a stale byte never looks valid by accident.
  task automatic send(input logic [7:0] cmd, input logic [7:0] args[$]);
    int i;
    @(negedge ref_clk);
    rxIn = {1'b1, PREFIX};
    @(negedge ref_clk);
    rxIn = {1'b1, cmd};
    for (i = 0; i < args.size(); i++) begin
      @(negedge ref_clk);
      rxIn = {1'b1, args[i]};
    end
    @(negedge ref_clk);
    rxIn = {1'b0, ~rxIn.data};
  endtask
  // Ready follows the stall request; a byte counts when valid meets ready.
  always @(negedge ref_clk) txReady <= !stallReq;
  always @(posedge ref_clk) begin
    if (txOut.valid && txReady) got.push_back(txOut.data);
  end
endmodule // kpe_host_model
`default_nettype wire

// file: keypad_event_handler_tb.sv
// Testbench of the keypad event handler.
`timescale 1ns/1ps
`default_nettype none
module keypad_event_handler_tb;
  import kpe_pkg::*;
  localparam logic [7:0] AUTO_EN = 8'h21;
  localparam logic [7:0] POLL = 8'h22;
  localparam logic [7:0] REP_OFF = 8'h23;
  logic ref_clk;
  logic rst_n;
  logic stallReq;
  logic [KEYS-1:0] keyRaw;
  kpe_byte_t rxIn;
  kpe_byte_t txOut;
  logic txReady;
  logic autoTx_ff;
  logic [BUF_W-1:0] bufCount_ff;
  int failures;
  int checks;
  int i;
  logic [7:0] q[$];
  logic [7:0] none[$];
  // ==========================================================================
  // Instances
  // Short tick and repeat counts keep the run brief.
  keypad_event_handler #(.CMD_AUTO_EN(AUTO_EN), .CMD_POLL(POLL), .CMD_REP_OFF(REP_OFF),
    .TICK_CYC(4), .DELAY_CYC(40), .PERIOD_CYC(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .keyRaw(keyRaw), .rxIn(rxIn), .txOut(txOut), .txReady(txReady),
    .autoTx_ff(autoTx_ff), .bufCount_ff(bufCount_ff));
  kpe_host_model host (.ref_clk(ref_clk), .stallReq(stallReq), .rxIn(rxIn),
    .txOut(txOut), .txReady(txReady));
  // Free-running 50 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits a bounded time for the next reply byte, then compares it.
  task automatic expectByte(input logic [7:0] exp);
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check((host.got.size() != 0) ? host.got.pop_front() : 8'hxx, exp);
  endtask
  // Holds one key down for n cycles, then lets the release settle.
  task automatic tap(input int k, input int n);
    @(negedge ref_clk);
    keyRaw[k] = 1'b1;
    repeat (n) @(negedge ref_clk);
    keyRaw[k] = 1'b0;
    repeat (40) @(negedge ref_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short; the tests need some two thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  // ==========================================================================
  // Tests
  initial begin
    keyRaw = '0;
    rst_n = 1'b0;
    stallReq = 1'b0;
    failures = 0;
    checks = 0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check({7'h0, autoTx_ff}, 8'h01);
    check({4'h0, bufCount_ff}, 8'h00);
    tap(0, 20);
    check(8'(host.got.size()), 8'h00);
    // Typematic repeats pile up in the FIFO while the host stalls.
    stallReq = 1'b1;
    tap(3, 400);
    stallReq = 1'b0;
    repeat (150) @(negedge ref_clk);
    check({7'h0, host.got.size() >= 32}, 8'h01);
    while (host.got.size() != 0) expectByte(8'h44);
    $display("test typematic done");
    q = {8'h02};
    host.send(CMD_DEBOUNCE, q);
    tap(5, 5);
    check(8'(host.got.size()), 8'h00);
    tap(5, 20);
    expectByte(8'h46);
    $display("test debounce done");
    // Only key 0 gets new codes; every other slot keeps its default.
    q.delete();
    for (i = 0; i < 50; i++) q.push_back((i == 0) ? 8'h30 : (i == 25) ? 8'h31 : KEEP_CODE);
    host.send(CMD_ASSIGN, q);
    q = {MODE_HOLD};
    host.send(CMD_REP_MODE, q);
    tap(0, 100);
    expectByte(8'h30);
    expectByte(8'h31);
    check(8'(host.got.size()), 8'h00);
    tap(1, 20);
    expectByte(8'h42);
    expectByte(8'h62);
    $display("test hold done");
    host.send(REP_OFF, none);
    tap(24, 100);
    expectByte(8'h59);
    check(8'(host.got.size()), 8'h00);
    $display("test repeat off done");
    // Mode byte zero selects typematic and brings repeat back after repeat off.
    q = {8'h00};
    host.send(CMD_REP_MODE, q);
    tap(23, 100);
    check({7'h0, host.got.size() >= 2}, 8'h01);
    while (host.got.size() != 0) expectByte(8'h58);
    $display("test typematic again done");
    // Eleven presses into a ten-entry buffer; the last one is lost.
    host.send(CMD_AUTO_OFF, none);
    check({7'h0, autoTx_ff}, 8'h00);
    for (i = 2; i < 13; i++) tap(i, 15);
    check({4'h0, bufCount_ff}, 8'h0a);
    for (i = 0; i < 10; i++) begin
      host.send(POLL, none);
      expectByte((i < 9) ? ((8'h43 + 8'(i)) | 8'h80) : 8'h4c);
    end
    host.send(POLL, none);
    expectByte(POLL_EMPTY);
    tap(13, 15);
    check({4'h0, bufCount_ff}, 8'h01);
    host.send(CMD_CLEAR, none);
    check({4'h0, bufCount_ff}, 8'h00);
    host.send(POLL, none);
    expectByte(POLL_EMPTY);
    $display("test polled done");
    host.send(AUTO_EN, none);
    check({7'h0, autoTx_ff}, 8'h01);
    host.send(POLL, none);
    repeat (20) @(negedge ref_clk);
    check(8'(host.got.size()), 8'h00);
    tap(14, 15);
    expectByte(8'h4f);
    $display("test auto on done");
    end_sim();
  end
endmodule // keypad_event_handler_tb
`default_nettype wire
